// ===== hw/clk_ctl_pkg.sv
/*
 Constants, field positions, reset values and carrier types for the
 high-speed oscillator control and system clock switch.
 Assumes a single 25 MHz logic clock and oscillator pulses that arrive
 as one-cycle strobes synchronous to it.
*/
// Contract
// - Power-on starts fast oscillator in RC mode
// - Hold system reset until start plus 8192
// - Software picks mode, then sets enable bit
// - Fast clock gated until start and stabilization
// - Stop state halts the fast oscillator
// - Wake restarts; supply after start plus 128
// - Software switches system clock; single variant cannot
// - Stall CPU until slow clock is supplied
// - Stall CPU until fast clock is supplied
// - Function bit 1 routes fast clock pin21
// - Pin21 drives when both config bit1 set
// - Pin21 clock ignores output data bit 1
// - Function bit 2 routes slow clock pin22
// - Pin22 drives when both config bit2 set
// - Pin22 clock ignores output data bit 2
// - Pins 21 and 22 are output only
// - Select bit 0: slow, 1: fast; resets 1
// - Enable bit 0 forces select bit to 0
package clk_ctl_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ADDR_W = 16;
   localparam logic [15:0] PORT2_OUTPUT_DATA_ADDR = 16'hf210;
   localparam logic [15:0] PORT2_DRIVE_CONFIG_LOW_ADDR = 16'hf212;
   localparam logic [15:0] PORT2_DRIVE_CONFIG_HIGH_ADDR = 16'hf213;
   localparam logic [15:0] PORT2_FUNCTION_SELECT_ADDR = 16'hf214;
   localparam logic [15:0] FREQ_CONTROL_REG_ZERO_ADDR = 16'hf002;
   localparam logic [15:0] FREQ_CONTROL_REG_ONE_ADDR = 16'hf003;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int SYS_SEL_BIT = 0;
   localparam int OSC_EN_BIT = 1;
   localparam int DIV_LSB = 0;
   localparam int MODE_BIT = 4;
   localparam int PIN21_BIT = 1;
   localparam int PIN22_BIT = 2;
   localparam int PORT_BITS = 3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] FREQ_CONTROL_REG_ZERO_RESET = 8'h00;
   localparam logic SYS_SEL_RESET = 1'b1;
   localparam logic OSC_EN_RESET = 1'b1;
   localparam logic [2:0] PORT_RESET = 3'h0;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int RC_START_TIME_NS = 100000;
   localparam int RC_START_CYCLES = (RC_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_STAB_COUNT = 8192;
   localparam int WAKE_STAB_COUNT = 128;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {OSC_OFF, OSC_START, OSC_STAB, OSC_RUN} osc_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_bus_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_t;

   typedef struct packed {
      osc_state_t osc;
      logic [15:0] startCnt;
      logic [13:0] stabCnt;
      logic [13:0] stabTarget;
      logic porPhase;
      logic stopped;
      logic [7:0] freq_control_reg_zero;
      logic sysSel;
      logic oscEn;
      logic [2:0] p2d;
      logic [2:0] p2c0;
      logic [2:0] p2c1;
      logic [2:0] port2_function_select;
      logic [2:0] divCnt;
      logic activeFast;
      logic stall;
      logic fastTick;
      logic sysTick;
      logic fastLevel;
      logic slowLevel;
      pin_t pin21;
      pin_t pin22;
      logic [7:0] rdData;
      logic sysResetn;
   } state_t;

endpackage

// ===== hw/high_speed_clock_and_system_clock_select_switch.sv
/*
 Fast RC oscillator sequencing, system clock source switch with CPU
 stall, and clock routing to port pins 21 and 22.
 Assumes oscillator and slow clock pulses are synchronous strobes, and
 that the slow clock block reports when its clock is being supplied.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module high_speed_clock_and_system_clock_select_switch #(
   parameter bit SINGLE_OSC = 1'b0,
   parameter int POR_STAB = clk_ctl_pkg::POR_STAB_COUNT,
   parameter int WAKE_STAB = clk_ctl_pkg::WAKE_STAB_COUNT,
   parameter int START_CYCLES = clk_ctl_pkg::RC_START_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire clk_ctl_pkg::reg_bus_t regBus,
   output logic [7:0] rdData,
   // Oscillator and slow clock sources
   input wire logic rcOscPulse,
   input wire logic extClkPulse,
   input wire logic slowClockPulse,
   input wire logic slowClockReady,
   // Low-power control
   input wire logic stopEnter,
   input wire logic wakeIrq,
   // Clock supply and CPU control
   output logic fastOscOn,
   output logic fastClockTick,
   output logic systemClockTick,
   output logic activeSourceFast,
   output logic cpuStall,
   output logic systemResetn,
   // Output-only port pins
   output clk_ctl_pkg::pin_t fastClockOutPin,
   output clk_ctl_pkg::pin_t slowClockOutPin
);
   import clk_ctl_pkg::*;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (POR_STAB < 1 || POR_STAB > 16383) begin : g_bad_por
      $error("POR_STAB out of range");
   end
   if (WAKE_STAB < 1 || WAKE_STAB > 16383) begin : g_bad_wake
      $error("WAKE_STAB out of range");
   end
   if (START_CYCLES < 1 || START_CYCLES > 65535) begin : g_bad_start
      $error("START_CYCLES out of range");
   end

   localparam logic [15:0] START_LAST = 16'(START_CYCLES - 1);
   localparam logic [13:0] POR_TARGET = 14'(POR_STAB);
   localparam logic [13:0] WAKE_TARGET = 14'(WAKE_STAB);

   // ****************************************************************
   // Divider limit from frequency select
   // ****************************************************************
   function automatic logic [2:0] divLimit(input logic [1:0] sel);
      case (sel)
         2'h0: divLimit = 3'h0;
         2'h1: divLimit = 3'h1;
         2'h2: divLimit = 3'h3;
         default: divLimit = 3'h7;
      endcase
   endfunction

   state_t s;
   state_t next_s;
   logic rawPulse;
   logic fastSupplied;
   logic wantFast;
   logic targetSupplied;
   logic slowTick;
   logic newEn;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_s = s;
      next_s.fastTick = 1'b0;
      next_s.sysTick = 1'b0;
      next_s.rdData = 8'h00;
      newEn = s.oscEn;
      rawPulse = s.freq_control_reg_zero[MODE_BIT] ? extClkPulse : rcOscPulse;
      slowTick = slowClockPulse & slowClockReady;

      // Oscillator sequencing
      case (s.osc)
         OSC_OFF: begin
            if (s.oscEn && !s.stopped) begin
               next_s.osc = OSC_START;
               next_s.startCnt = 16'h0000;
               next_s.stabTarget = WAKE_TARGET;
            end
         end
         OSC_START: begin
            if (s.startCnt == START_LAST) begin
               next_s.osc = OSC_STAB;
               next_s.stabCnt = 14'h0000;
            end else begin
               next_s.startCnt = s.startCnt + 16'h0001;
            end
         end
         OSC_STAB: begin
            if (rawPulse) begin
               if (s.stabCnt == s.stabTarget - 14'h0001) begin
                  next_s.osc = OSC_RUN;
                  next_s.divCnt = 3'h0;
                  if (s.porPhase) begin
                     next_s.porPhase = 1'b0;
                     next_s.sysResetn = 1'b1;
                  end
               end else begin
                  next_s.stabCnt = s.stabCnt + 14'h0001;
               end
            end
         end
         OSC_RUN: begin
            if (rawPulse) begin
               if (s.divCnt >= divLimit(s.freq_control_reg_zero[DIV_LSB +: 2])) begin
                  next_s.divCnt = 3'h0;
                  next_s.fastTick = 1'b1;
               end else begin
                  next_s.divCnt = s.divCnt + 3'h1;
               end
            end
         end
         default: begin
            next_s.osc = OSC_OFF;
         end
      endcase

      // Stop entry and wake-up
      if (stopEnter && s.sysResetn && !s.stopped) begin
         next_s.stopped = 1'b1;
         next_s.osc = OSC_OFF;
         next_s.fastTick = 1'b0;
      end else if (wakeIrq && s.stopped) begin
         next_s.stopped = 1'b0;
      end

      // Register writes
      if (regBus.wr) begin
         case (regBus.addr)
            FREQ_CONTROL_REG_ZERO_ADDR: begin
               next_s.freq_control_reg_zero = regBus.wdata;
            end
            FREQ_CONTROL_REG_ONE_ADDR: begin
               if (!SINGLE_OSC) begin
                  newEn = regBus.wdata[OSC_EN_BIT];
                  next_s.oscEn = newEn;
                  next_s.sysSel = regBus.wdata[SYS_SEL_BIT] & newEn;
               end
            end
            PORT2_OUTPUT_DATA_ADDR: begin
               next_s.p2d = regBus.wdata[PORT_BITS-1:0];
            end
            PORT2_DRIVE_CONFIG_LOW_ADDR: begin
               next_s.p2c0 = regBus.wdata[PORT_BITS-1:0];
            end
            PORT2_DRIVE_CONFIG_HIGH_ADDR: begin
               next_s.p2c1 = regBus.wdata[PORT_BITS-1:0];
            end
            PORT2_FUNCTION_SELECT_ADDR: begin
               next_s.port2_function_select = regBus.wdata[PORT_BITS-1:0];
            end
            default: begin
            end
         endcase
      end
      if (!s.oscEn && !s.porPhase) begin
         next_s.osc = OSC_OFF;
         next_s.fastTick = 1'b0;
      end

      // System clock source switch
      fastSupplied = (s.osc == OSC_RUN);
      wantFast = SINGLE_OSC ? 1'b1 : s.sysSel;
      targetSupplied = wantFast ? fastSupplied : slowClockReady;
      if (wantFast != s.activeFast && targetSupplied) begin
         next_s.activeFast = wantFast;
      end
      next_s.stall = s.sysResetn && !targetSupplied;
      if (next_s.activeFast == s.activeFast) begin
         next_s.sysTick = s.activeFast ? next_s.fastTick : slowTick;
      end

      // Clock levels for the pins
      if (next_s.fastTick) begin
         next_s.fastLevel = ~s.fastLevel;
      end
      if (slowTick) begin
         next_s.slowLevel = ~s.slowLevel;
      end
      next_s.pin21.out = s.port2_function_select[PIN21_BIT] ? s.fastLevel : s.p2d[PIN21_BIT];
      next_s.pin21.oe = s.p2c0[PIN21_BIT] & s.p2c1[PIN21_BIT];
      next_s.pin22.out = s.port2_function_select[PIN22_BIT] ? s.slowLevel : s.p2d[PIN22_BIT];
      next_s.pin22.oe = s.p2c0[PIN22_BIT] & s.p2c1[PIN22_BIT];

      // Register reads
      if (regBus.rd) begin
         case (regBus.addr)
            FREQ_CONTROL_REG_ZERO_ADDR: next_s.rdData = s.freq_control_reg_zero;
            FREQ_CONTROL_REG_ONE_ADDR: begin
               next_s.rdData[OSC_EN_BIT] = SINGLE_OSC ? 1'b1 : s.oscEn;
               next_s.rdData[SYS_SEL_BIT] = SINGLE_OSC ? 1'b1 : s.sysSel;
            end
            PORT2_OUTPUT_DATA_ADDR: next_s.rdData = {5'h00, s.p2d};
            PORT2_DRIVE_CONFIG_LOW_ADDR: next_s.rdData = {5'h00, s.p2c0};
            PORT2_DRIVE_CONFIG_HIGH_ADDR: next_s.rdData = {5'h00, s.p2c1};
            PORT2_FUNCTION_SELECT_ADDR: next_s.rdData = {5'h00, s.port2_function_select};
            default: next_s.rdData = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s <= '0;
         s.osc <= OSC_START;
         s.stabTarget <= POR_TARGET;
         s.porPhase <= 1'b1;
         s.freq_control_reg_zero <= FREQ_CONTROL_REG_ZERO_RESET;
         s.sysSel <= SYS_SEL_RESET;
         s.oscEn <= OSC_EN_RESET;
         s.p2d <= PORT_RESET;
         s.p2c0 <= PORT_RESET;
         s.p2c1 <= PORT_RESET;
         s.port2_function_select <= PORT_RESET;
         s.activeFast <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign rdData = s.rdData;
   assign fastOscOn = (s.osc != OSC_OFF);
   assign fastClockTick = s.fastTick;
   assign systemClockTick = s.sysTick;
   assign activeSourceFast = s.activeFast;
   assign cpuStall = s.stall;
   assign systemResetn = s.sysResetn;
   assign fastClockOutPin = s.pin21;
   assign slowClockOutPin = s.pin22;

endmodule

`default_nettype wire

// ===== dv/clk_switch_props.sv
/*
 Checker for the fast oscillator and system clock switch ports.
 Bound into the top module; sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module clk_switch_props #(
   parameter int POR_STAB = 16,
   parameter int WAKE_STAB = 4
) (
   // Watched ports
   input wire logic clk,
   input wire logic resetn,
   input wire clk_ctl_pkg::reg_bus_t regBus,
   input wire logic [7:0] rdData,
   input wire logic rcOscPulse,
   input wire logic slowClockReady,
   input wire logic stopEnter,
   input wire logic fastOscOn,
   input wire logic fastClockTick,
   input wire logic activeSourceFast,
   input wire logic systemResetn,
   input wire logic systemClockTick,
   input wire logic slowClockPulse
);
   import clk_ctl_pkg::*;
   // ********************
   // Pulses since start
   // ********************
   logic [15:0] pulseCnt;
   always_ff @(posedge clk) begin
      if (!resetn || !fastOscOn) begin
         pulseCnt <= 16'h0000;
      end else if (rcOscPulse && pulseCnt != 16'hffff) begin
         pulseCnt <= pulseCnt + 16'h0001;
      end
   end
   logic slowTickPrev;
   always_ff @(posedge clk) begin
      slowTickPrev <= slowClockPulse && slowClockReady;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_stop_req;
      stopEnter && systemResetn && fastOscOn;
   endsequence
   sequence s_on_fast;
      activeSourceFast && $past(activeSourceFast);
   endsequence
   sequence s_on_slow;
      !activeSourceFast && !$past(activeSourceFast);
   endsequence
   a_por_start: assert property (!$past(resetn) |-> fastOscOn && activeSourceFast)
      else $error("reset state wrong");
   a_por_hold: assert property ($rose(systemResetn) |-> pulseCnt >= POR_STAB)
      else $error("system reset released early");
   a_wake_stab: assert property (fastClockTick |-> pulseCnt >= WAKE_STAB)
      else $error("fast clock before stabilization");
   a_tick_off: assert property (!fastOscOn |=> !fastClockTick)
      else $error("fast clock while off");
   a_stop_halt: assert property (s_stop_req |=> !fastOscOn)
      else $error("stop left oscillator on");
   a_slow_gate: assert property (!slowClockReady && activeSourceFast |=> activeSourceFast)
      else $error("switched to absent slow clock");
   a_fast_gate: assert property (!fastOscOn && !activeSourceFast |=> !activeSourceFast)
      else $error("switched to absent fast clock");
   a_rd_idle: assert property (!$past(regBus.rd) |-> rdData == 8'h00)
      else $error("read data outside read slot");
   a_sys_fast: assert property (s_on_fast |-> systemClockTick == fastClockTick)
      else $error("system tick not from fast clock");
   a_sys_slow: assert property (s_on_slow |-> systemClockTick == slowTickPrev)
      else $error("system tick not from slow clock");
   a_switch_quiet: assert property ($changed(activeSourceFast) |-> !systemClockTick)
      else $error("system tick in switch cycle");
endmodule
bind high_speed_clock_and_system_clock_select_switch clk_switch_props #(
   .POR_STAB(POR_STAB), .WAKE_STAB(WAKE_STAB)) props (.clk, .resetn, .regBus, .rdData,
   .rcOscPulse, .slowClockReady, .stopEnter, .fastOscOn, .fastClockTick, .activeSourceFast,
   .systemResetn, .systemClockTick, .slowClockPulse);
`default_nettype wire

// ===== dv/clk_src_model.sv
/*
 Clock source model: RC oscillator and slow clock pulse strobes.
 Assumes one logic clock; the slow clock runs while slowRun is high.
*/
`timescale 1ns/100ps
`default_nettype none
module clk_src_model (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic fastOscOn,
   input wire logic slowRun,
   // Pulse strobes
   output logic rcOscPulse,
   output logic slowClockPulse,
   output logic slowClockReady
);
   // ********************
   // Dividers
   // ********************
   logic [2:0] rcDiv;
   logic [2:0] slDiv;
   always_ff @(posedge clk) begin
      if (!resetn || !fastOscOn) begin
         rcDiv <= 3'h0;
      end else begin
         rcDiv <= (rcDiv == 3'h2) ? 3'h0 : rcDiv + 3'h1;
      end
      if (!slowRun) begin
         slDiv <= 3'h0;
         slowClockReady <= 1'b0;
      end else begin
         slDiv <= (slDiv == 3'h4) ? 3'h0 : slDiv + 3'h1;
         slowClockReady <= slowClockReady | (slDiv == 3'h4);
      end
   end
   assign rcOscPulse = resetn && fastOscOn && rcDiv == 3'h2;
   assign slowClockPulse = slowRun && slDiv == 3'h4;
endmodule
`default_nettype wire

// ===== dv/tb_high_speed_clock_and_system_clock_select_switch.sv
/*
 Testbench for the oscillator control and clock switch.
 Assumes the clock source model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_high_speed_clock_and_system_clock_select_switch;
   import clk_ctl_pkg::*;
   // ********************
   // Bench
   // ********************
   logic clk, resetn, stopEnter, wakeIrq, slowRun, extPulse;
   reg_bus_t regBus;
   logic [7:0] rdData;
   logic rcOscPulse, slowClockPulse, slowClockReady, fastOscOn, fastClockTick;
   logic systemClockTick, activeSourceFast, cpuStall, systemResetn;
   pin_t fastPin, slowPin;
   int fails, checks_done, gap;
   typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   row_t rows[6] = '{'{16'hf210, 8'hff, 8'h07}, '{16'hf212, 8'h06, 8'h06},
      '{16'hf213, 8'h02, 8'h02}, '{16'hf214, 8'h06, 8'h06}, '{16'hf211, 8'h5a, 8'h00},
      '{16'hf003, 8'h03, 8'h03}};
   high_speed_clock_and_system_clock_select_switch #(.SINGLE_OSC(1'b0), .POR_STAB(16), .WAKE_STAB(4),
      .START_CYCLES(4)) dut (.clk, .resetn, .regBus, .rdData, .rcOscPulse,
      .extClkPulse(extPulse), .slowClockPulse, .slowClockReady, .stopEnter, .wakeIrq,
      .fastOscOn, .fastClockTick, .systemClockTick, .activeSourceFast, .cpuStall,
      .systemResetn, .fastClockOutPin(fastPin), .slowClockOutPin(slowPin));
   clk_src_model src (.clk, .resetn, .fastOscOn, .slowRun, .rcOscPulse, .slowClockPulse,
      .slowClockReady);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      regBus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      regBus.rd <= 1'b0;
      @(negedge clk);
      chk(rdData, e);
   endtask
   task automatic waitFor(input int sel, input logic v);
      int n;
      for (n = 0; n < 2000; n++) begin
         @(negedge clk);
         if (sel == 0 && systemResetn === v || sel == 1 && activeSourceFast === v ||
            sel == 2 && cpuStall === v || sel == 3 && fastClockTick === v) break;
      end
      if (n == 2000) begin
         fails++;
         summarize();
      end
   endtask
   task automatic pins(input logic [7:0] exp);
      logic p21, p22;
      logic [7:0] seen;
      p21 = fastPin.out;
      p22 = slowPin.out;
      seen = 8'h00;
      repeat (60) begin
         @(negedge clk);
         if (fastPin.out !== p21) seen[2] = 1'b1;
         if (slowPin.out !== p22) seen[0] = 1'b1;
         p21 = fastPin.out;
         p22 = slowPin.out;
      end
      seen[3] = fastPin.oe;
      seen[1] = slowPin.oe;
      chk(seen, exp);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      fails = 0;
      checks_done = 0;
      resetn = 1'b0;
      stopEnter = 1'b0;
      wakeIrq = 1'b0;
      slowRun = 1'b0;
      extPulse = 1'b0;
      regBus = '0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk({4'h0, fastOscOn, activeSourceFast, systemResetn, cpuStall}, 8'h0c);
      waitFor(0, 1'b1);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      pins(8'h0c);
      wr(FREQ_CONTROL_REG_ONE_ADDR, 8'h02);
      repeat (3) @(negedge clk);
      chk({6'h0, activeSourceFast, cpuStall}, 8'h03);
      @(posedge clk) slowRun <= 1'b1;
      waitFor(1, 1'b0);
      waitFor(2, 1'b0);
      wr(PORT2_DRIVE_CONFIG_HIGH_ADDR, 8'h06);
      pins(8'h0f);
      wr(PORT2_FUNCTION_SELECT_ADDR, 8'h00);
      repeat (3) @(negedge clk);
      chk({6'h0, fastPin.out, slowPin.out}, 8'h03);
      wr(FREQ_CONTROL_REG_ONE_ADDR, 8'h01);
      rd(FREQ_CONTROL_REG_ONE_ADDR, 8'h00);
      chk({7'h0, fastOscOn}, 8'h00);
      wr(FREQ_CONTROL_REG_ONE_ADDR, 8'h03);
      repeat (2) @(negedge clk);
      chk({6'h0, fastOscOn, cpuStall}, 8'h03);
      waitFor(1, 1'b1);
      wr(FREQ_CONTROL_REG_ZERO_ADDR, 8'h01);
      waitFor(3, 1'b1);
      gap = 0;
      do begin
         @(negedge clk);
         gap++;
      end while (fastClockTick !== 1'b1 && gap < 100);
      chk(8'(gap), 8'h06);
      chk({7'h0, systemClockTick}, 8'h01);
      wr(FREQ_CONTROL_REG_ZERO_ADDR, 8'h10);
      @(posedge clk) extPulse <= 1'b1;
      repeat (2) @(negedge clk);
      chk({6'h0, fastClockTick, systemClockTick}, 8'h03);
      @(negedge clk);
      chk({6'h0, fastClockTick, systemClockTick}, 8'h03);
      @(posedge clk) extPulse <= 1'b0;
      wr(FREQ_CONTROL_REG_ZERO_ADDR, 8'h00);
      chk({7'h0, slowClockReady}, 8'h01);
      wr(FREQ_CONTROL_REG_ONE_ADDR, 8'h02);
      repeat (2) @(negedge clk);
      chk({6'h0, activeSourceFast, cpuStall}, 8'h00);
      wr(FREQ_CONTROL_REG_ONE_ADDR, 8'h03);
      waitFor(1, 1'b1);
      @(posedge clk) stopEnter <= 1'b1;
      @(posedge clk) stopEnter <= 1'b0;
      @(negedge clk);
      chk({7'h0, fastOscOn}, 8'h00);
      @(posedge clk) wakeIrq <= 1'b1;
      @(posedge clk) wakeIrq <= 1'b0;
      waitFor(3, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
